// [hw/i2c_master_command_sequencer.sv]
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module i2c_master_command_sequencer (
  input wire logic clk_in, // System clock, 250 MHz
  input wire logic nrst_in, // Async reset, active low
  input wire logic [7:0] axi_awaddr_in, // Write address
  input wire logic axi_awvalid_in, // Write address valid
  output logic axi_awready_out, // Write address ready
  input wire logic [31:0] axi_wdata_in, // Write data
  input wire logic [3:0] axi_wstrb_in, // Write strobes
  input wire logic axi_wvalid_in, // Write data valid
  output logic axi_wready_out, // Write data ready
  output logic [1:0] axi_bresp_out, // Write response
  output logic axi_bvalid_out, // Write response valid
  input wire logic axi_bready_in, // Write response ready
  input wire logic [7:0] axi_araddr_in, // Read address
  input wire logic axi_arvalid_in, // Read address valid
  output logic axi_arready_out, // Read address ready
  output logic [31:0] axi_rdata_out, // Read data
  output logic [1:0] axi_rresp_out, // Read response
  output logic axi_rvalid_out, // Read data valid
  input wire logic axi_rready_in, // Read data ready
  input wire logic scl_in, // Clock line level
  output logic scl_level_out, // Clock line drive level
  output logic scl_oe_out, // Clock line pulled low
  input wire logic sda_in, // Data line level
  output logic sda_level_out, // Data line drive level
  output logic sda_oe_out, // Data line pulled low
  output logic irq_out // Masked completion interrupt
);
  import i2c_master_pkg::*;

  typedef struct packed {
    ctl_mode_t mode;
    seq_t seq;
    logic busy;
    logic arb;
    logic dnack;
    logic anack;
    logic err;
    logic rx;
    logic ackb;
    logic stopp;
    logic scl_oe;
    logic sda_oe;
    logic imask;
    logic iraw;
    logic bvalid;
    logic rvalid;
    logic [7:0] tgt;
    logic [7:0] data;
    logic [7:0] clock_period_value;
    logic [7:0] cfg;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic [4:0] ph;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } main_state_t;

  main_state_t st_r, st_nxt;
  logic tick_w, occ_w, wr_go, rd_go, cmd_wr;
  logic [7:0] wd;

  // --------------------------------------------------------------
  // Bit timing and bus watch
  // --------------------------------------------------------------
  i2c_tick_gen u_tick (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .period_in(st_r.clock_period_value),
    .tick_out(tick_w)
  );

  i2c_line_watch u_watch (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .occupied_out(occ_w)
  );

  // --------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------
  assign wd = axi_wdata_in[7:0];
  assign wr_go = axi_awvalid_in && axi_wvalid_in && !st_r.bvalid;
  assign rd_go = axi_arvalid_in && !st_r.rvalid;
  assign cmd_wr = wr_go && axi_awaddr_in == OFS_CMD && axi_wstrb_in[0];

  // --------------------------------------------------------------
  // Registers, command decode and bit engine
  // --------------------------------------------------------------
  always_comb begin
    logic c_go;
    logic c_rx;
    logic c_stop;
    logic adv;
    logic drv;
    logic txbit;
    ctl_mode_t c_next;
    st_nxt = st_r;
    c_go = 1'b0;
    c_rx = (st_r.mode == M_RX);
    c_stop = wd[CMD_STOP_BIT];
    adv = 1'b0;
    drv = 1'b1;
    txbit = 1'b0;
    c_next = M_IDLE;
    // Command decode against the current controller state
    if (wd[CMD_START_BIT] && wd[CMD_RUN_BIT]) begin
      c_rx = st_r.tgt[TGT_DIR_BIT];
      if (st_r.mode == M_TX && c_rx && !wd[CMD_ACK_BIT] && c_stop) begin
        c_rx = 1'b0;
      end
      c_go = !(c_rx && wd[CMD_ACK_BIT] && c_stop);
    end else if (!wd[CMD_START_BIT] && st_r.mode != M_IDLE) begin
      if (wd[CMD_RUN_BIT]) begin
        c_go = !(c_rx && wd[CMD_ACK_BIT] && c_stop);
      end else begin
        c_go = c_stop;
      end
    end
    c_next = c_stop ? M_IDLE : (c_rx ? M_RX : M_TX);
    if (st_r.bvalid && axi_bready_in) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && axi_rready_in) begin
      st_nxt.rvalid = 1'b0;
    end
    // Register writes
    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (axi_awaddr_in)
        OFS_TARGET: if (axi_wstrb_in[0]) st_nxt.tgt = wd;
        OFS_DATA: if (axi_wstrb_in[0]) st_nxt.data = wd;
        OFS_PERIOD: if (axi_wstrb_in[0]) st_nxt.clock_period_value = wd;
        OFS_IMASK: if (axi_wstrb_in[0]) st_nxt.imask = wd[0];
        OFS_ICLR: if (axi_wstrb_in[0] && wd[0]) st_nxt.iraw = 1'b0;
        OFS_CONFIG: if (axi_wstrb_in[0]) st_nxt.cfg = wd & CFG_MASK;
        OFS_CMD, OFS_IRAW, OFS_IMASKED: ;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    // Accept a command only while the controller is free
    if (cmd_wr && !st_r.busy && c_go) begin
      st_nxt.busy = 1'b1;
      st_nxt.mode = c_next;
      st_nxt.rx = c_rx;
      st_nxt.ackb = wd[CMD_ACK_BIT];
      st_nxt.stopp = c_stop;
      st_nxt.arb = 1'b0;
      st_nxt.dnack = 1'b0;
      st_nxt.anack = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.ph = 5'h00;
      st_nxt.bitc = 4'h0;
      st_nxt.sh = st_r.data;
      if (!wd[CMD_RUN_BIT]) begin
        st_nxt.seq = SQ_STOP;
      end else if (wd[CMD_START_BIT]) begin
        st_nxt.seq = SQ_START;
      end else begin
        st_nxt.seq = SQ_DATA;
      end
    end
    // Register reads
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = '0;
      case (axi_araddr_in)
        OFS_TARGET: st_nxt.rdata[7:0] = st_r.tgt;
        OFS_CMD: begin
          st_nxt.rdata[ST_BUS_OCC] = occ_w;
          st_nxt.rdata[ST_IDLE] = st_r.mode == M_IDLE && !st_r.busy;
          st_nxt.rdata[ST_ARB] = st_r.arb;
          st_nxt.rdata[ST_DNACK] = st_r.dnack;
          st_nxt.rdata[ST_ANACK] = st_r.anack;
          st_nxt.rdata[ST_ERR] = st_r.err;
          st_nxt.rdata[ST_BUSY] = st_r.busy;
        end
        OFS_DATA: st_nxt.rdata[7:0] = st_r.data;
        OFS_PERIOD: st_nxt.rdata[7:0] = st_r.clock_period_value;
        OFS_IMASK: st_nxt.rdata[0] = st_r.imask;
        OFS_IRAW: st_nxt.rdata[0] = st_r.iraw;
        OFS_IMASKED: st_nxt.rdata[0] = st_r.iraw && st_r.imask;
        OFS_CONFIG: st_nxt.rdata[7:0] = st_r.cfg;
        OFS_ICLR: ;
        default: st_nxt.rresp = RESP_SLVERR;
      endcase
    end
    // Value offered on the data line for the current bit
    unique case (st_r.seq)
      SQ_IDLE: drv = 1'b1;
      SQ_START: drv = 1'b1;
      SQ_STOP: drv = 1'b0;
      SQ_ADDR: begin
        txbit = st_r.bitc != ACK_SLOT;
        drv = txbit ? st_r.sh[7] : 1'b1;
      end
      SQ_DATA: begin
        txbit = !st_r.rx && st_r.bitc != ACK_SLOT;
        if (st_r.rx) begin
          drv = (st_r.bitc == ACK_SLOT) ? !st_r.ackb : 1'b1;
        end else begin
          drv = txbit ? st_r.sh[7] : 1'b1;
        end
      end
    endcase
    // Clock stretching holds the phase while the line stays low
    if (st_r.seq != SQ_IDLE && tick_w) begin
      adv = !(st_r.ph >= HIGH_START && !st_r.scl_oe && !scl_in);
    end
    if (adv) begin
      st_nxt.ph = st_r.ph + 5'h01;
      if (st_r.ph == 5'h00) begin
        st_nxt.scl_oe = 1'b1;
        st_nxt.sda_oe = !drv;
      end
      if (st_r.ph == HIGH_START) begin
        st_nxt.scl_oe = 1'b0;
      end
      if (st_r.ph == SAMPLE_TICK) begin
        if (st_r.seq == SQ_START) begin
          st_nxt.sda_oe = 1'b1;
        end else if (st_r.seq == SQ_STOP) begin
          st_nxt.sda_oe = 1'b0;
        end else if (txbit && drv && !sda_in) begin
          st_nxt.arb = 1'b1;
          st_nxt.err = 1'b1;
          st_nxt.scl_oe = 1'b0;
          st_nxt.sda_oe = 1'b0;
          st_nxt.seq = SQ_IDLE;
          st_nxt.mode = M_IDLE;
          st_nxt.busy = 1'b0;
          st_nxt.iraw = 1'b1;
        end else if (st_r.seq == SQ_ADDR && !txbit) begin
          st_nxt.anack = sda_in;
          st_nxt.err = sda_in;
        end else if (st_r.seq == SQ_DATA && !st_r.rx && !txbit) begin
          st_nxt.dnack = sda_in;
          st_nxt.err = sda_in;
        end else if (st_r.seq == SQ_DATA && st_r.rx && st_r.bitc != ACK_SLOT) begin
          st_nxt.sh = {st_r.sh[6:0], sda_in};
        end
      end
      if (st_r.ph == BIT_TICKS - 5'h01) begin
        st_nxt.ph = 5'h00;
        unique case (st_r.seq)
          SQ_IDLE: ;
          SQ_START: begin
            st_nxt.seq = SQ_ADDR;
            st_nxt.bitc = 4'h0;
            st_nxt.sh = st_r.tgt;
          end
          SQ_ADDR: begin
            if (st_r.bitc != ACK_SLOT) begin
              st_nxt.bitc = st_r.bitc + 4'h1;
              st_nxt.sh = {st_r.sh[6:0], 1'b0};
            end else if (st_r.anack) begin
              st_nxt.seq = SQ_STOP;
              st_nxt.mode = M_IDLE;
            end else begin
              st_nxt.seq = SQ_DATA;
              st_nxt.bitc = 4'h0;
              st_nxt.sh = st_r.data;
            end
          end
          SQ_DATA: begin
            if (st_r.bitc != ACK_SLOT) begin
              st_nxt.bitc = st_r.bitc + 4'h1;
              if (!st_r.rx) begin
                st_nxt.sh = {st_r.sh[6:0], 1'b0};
              end
            end else begin
              if (st_r.rx) begin
                st_nxt.data = st_r.sh;
              end
              if (st_r.dnack || st_r.stopp) begin
                st_nxt.seq = SQ_STOP;
                st_nxt.mode = M_IDLE;
              end else begin
                st_nxt.seq = SQ_IDLE;
                st_nxt.scl_oe = 1'b1;
                st_nxt.sda_oe = 1'b0;
                st_nxt.busy = 1'b0;
                st_nxt.iraw = 1'b1;
              end
            end
          end
          SQ_STOP: begin
            st_nxt.seq = SQ_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.iraw = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      st_r.clock_period_value <= RST_PERIOD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign axi_awready_out = wr_go;
  assign axi_wready_out = wr_go;
  assign axi_bvalid_out = st_r.bvalid;
  assign axi_bresp_out = st_r.bresp;
  assign axi_arready_out = !st_r.rvalid;
  assign axi_rvalid_out = st_r.rvalid;
  assign axi_rdata_out = st_r.rdata;
  assign axi_rresp_out = st_r.rresp;
  assign scl_level_out = 1'b0;
  assign sda_level_out = 1'b0;
  assign scl_oe_out = st_r.scl_oe;
  assign sda_oe_out = st_r.sda_oe;
  assign irq_out = st_r.iraw && st_r.imask;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence idle_cmd_s(logic d, logic [3:0] c);
    cmd_wr && !st_r.busy && st_r.mode == M_IDLE && st_r.tgt[TGT_DIR_BIT] == d
    && axi_wdata_in[3:0] == c;
  endsequence

  sequence line_sample_s(seq_t s);
    st_r.seq == s && st_r.ph == SAMPLE_TICK && tick_w && !st_r.scl_oe && scl_in;
  endsequence

  tx_enter_a: assert property (idle_cmd_s(1'b0, 4'h3) |=>
    st_r.busy && st_r.mode == M_TX && st_r.seq == SQ_START)
    else $error("send without stop did not enter transmit");

  single_send_a: assert property (idle_cmd_s(1'b0, 4'h7) |=>
    st_r.busy && st_r.mode == M_IDLE && st_r.stopp && !st_r.rx)
    else $error("single send not set up");

  rx_enter_a: assert property (idle_cmd_s(1'b1, 4'hB) or idle_cmd_s(1'b1, 4'h3) |=>
    st_r.mode == M_RX && st_r.rx && st_r.ackb == $past(axi_wdata_in[CMD_ACK_BIT]))
    else $error("receive not entered");

  nop_cmd_a: assert property (idle_cmd_s(1'b1, 4'hF) or
    (cmd_wr && !st_r.busy && st_r.mode == M_IDLE && !axi_wdata_in[CMD_START_BIT])
    |=> !st_r.busy && $stable(st_r.mode) && $stable(st_r.scl_oe))
    else $error("illegal command acted");

  start_cond_a: assert property (line_sample_s(SQ_START) |=>
    st_r.sda_oe && !st_r.scl_oe ##1 st_r.sda_oe)
    else $error("start condition not driven");

  stop_cond_a: assert property (line_sample_s(SQ_STOP) |=>
    !st_r.sda_oe && !st_r.scl_oe)
    else $error("stop condition not driven");

  err_sum_a: assert property (!st_r.busy |->
    st_r.err == (st_r.arb || st_r.anack || st_r.dnack))
    else $error("error flag disagrees with causes");

  done_irq_a: assert property ($fell(st_r.busy) |-> st_r.iraw)
    else $error("completion without interrupt");

  arb_abort_a: assert property ($rose(st_r.arb) |->
    !st_r.busy && !st_r.scl_oe && !st_r.sda_oe && st_r.mode == M_IDLE)
    else $error("arbitration loss did not release bus");

  addr_field_a: assert property (wr_go && axi_awaddr_in == OFS_TARGET &&
    axi_wstrb_in[0] && axi_wdata_in == 32'h00000076 |=>
    st_r.tgt[7:1] == 7'h3B && !st_r.tgt[TGT_DIR_BIT])
    else $error("target address field misplaced");
endmodule // i2c_master_command_sequencer

// [hw/i2c_master_pkg.sv]
// Summary of operation
// - Bit period is twenty ticks of period plus one
// - Target register: seven address bits, one direction
// - Address in bits 7:1, direction in bit 0
// - Command bits: ack, stop, start, run
// - Start bit makes START or repeated START
// - Stop bit ends cycle or keeps burst
// - Ack bit acknowledges received bytes automatically
// - Completion or abort raises interrupt, data readable
// - Bus occupied follows any START and STOP
// - Status bit 4 reports lost arbitration
// - Status bit 3 reports data not acknowledged
// - Status bit 2 reports address not acknowledged
// - Status bit 1 is any of those errors
// - Status bit 0 busy during commanded operation
// - Idle send without stop enters transmit
// - Idle send with stop returns to idle
// - Idle receive without ack sends negative ack
// - Idle receive with stop returns to idle
// - Idle receive with ack enters receive state
// - Transmit: run sends, stop ends, both combine
// - Transmit: repeated START then send, optional stop
// - Transmit: repeated START then receive, ack choice
package i2c_master_pkg;
  localparam logic [7:0] OFS_TARGET = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  localparam logic [7:0] OFS_IRAW = 8'h14;
  localparam logic [7:0] OFS_IMASKED = 8'h18;
  localparam logic [7:0] OFS_ICLR = 8'h1C;
  localparam logic [7:0] OFS_CONFIG = 8'h20;
  localparam logic [7:0] RST_PERIOD = 8'h01;
  localparam logic [7:0] CFG_MASK = 8'h31;
  localparam int TGT_DIR_BIT = 0;
  localparam int CMD_ACK_BIT = 3;
  localparam int CMD_STOP_BIT = 2;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_RUN_BIT = 0;
  localparam int ST_BUS_OCC = 6;
  localparam int ST_IDLE = 5;
  localparam int ST_ARB = 4;
  localparam int ST_DNACK = 3;
  localparam int ST_ANACK = 2;
  localparam int ST_ERR = 1;
  localparam int ST_BUSY = 0;
  localparam int SCL_LOW_PHASE = 6;
  localparam int SCL_HIGH_PHASE = 4;
  localparam logic [4:0] BIT_TICKS = 5'(2 * (SCL_LOW_PHASE + SCL_HIGH_PHASE));
  localparam logic [4:0] HIGH_START = 5'(2 * SCL_LOW_PHASE);
  localparam logic [4:0] SAMPLE_TICK = 5'(2 * SCL_LOW_PHASE + SCL_HIGH_PHASE);
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_TX = 2'b01, M_RX = 2'b10} ctl_mode_t;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_START = 3'b001, SQ_ADDR = 3'b010, SQ_DATA = 3'b011, SQ_STOP = 3'b100
  } seq_t;
endpackage

// [hw/i2c_tick_gen.sv]
`timescale 1ns/1ns
module i2c_tick_gen (
  input wire logic clk_in, // System clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic [7:0] period_in, // Programmed period value
  output logic tick_out // One pulse per period plus one
);
  import i2c_master_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tick_state_t;
  tick_state_t st_r, st_nxt;
  logic [7:0] gap_r;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = (st_r.cnt >= period_in);
    st_nxt.cnt = st_nxt.tick ? 8'h00 : st_r.cnt + 8'h01;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      gap_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      gap_r <= st_r.tick ? 8'h00 : gap_r + 8'h01;
    end
  end

  assign tick_out = st_r.tick;

  tick_gap_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    st_r.tick && $stable(period_in) && gap_r == period_in
    |=> st_r.tick == ($past(period_in) == 8'h00))
    else $error("tick period mismatch");
endmodule // i2c_tick_gen

// [hw/i2c_line_watch.sv]
`timescale 1ns/1ns
module i2c_line_watch (
  input wire logic clk_in, // System clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic scl_in, // Clock line level
  input wire logic sda_in, // Data line level
  output logic occupied_out // Bus seen busy
);
  import i2c_master_pkg::*;
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic occ;
  } watch_state_t;
  watch_state_t st_r, st_nxt;
  logic start_w, stop_w;

  assign start_w = st_r.scl_q && scl_in && st_r.sda_q && !sda_in;
  assign stop_w = st_r.scl_q && scl_in && !st_r.sda_q && sda_in;

  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_q = scl_in;
    st_nxt.sda_q = sda_in;
    if (start_w) begin
      st_nxt.occ = 1'b1;
    end else if (stop_w) begin
      st_nxt.occ = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= 3'b110;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign occupied_out = st_r.occ;

  bus_occ_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    start_w |=> occupied_out ##1 (occupied_out || $past(stop_w)))
    else $error("bus occupied not set on start");
endmodule // i2c_line_watch

// [tb/i2c_slave_model.sv]
`timescale 1ns/1ns
module i2c_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h3B // Target address answered
) (
  input wire logic clk_in, // System clock
  input wire logic scl_in, // Resolved clock line
  input wire logic sda_in, // Resolved data line
  input wire logic nack_in, // Refuse every byte
  input wire logic stretch_in, // Hold clock line low
  input wire logic [7:0] tx_byte_in, // Byte returned on reads
  output logic scl_oe_out, // Pulls clock line low
  output logic sda_oe_out // Pulls data line low
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic first = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] got_q[$];
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    scl_oe_out <= stretch_in && (scl_oe_out || !scl_in);
    if (scl_in && scl_q && sda_q && !sda_in) begin
      cnt <= 4'h0;
      first <= 1'b1;
      sel <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (scl_in && scl_q && !sda_q && sda_in) begin
      sel <= 1'b0;
      first <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (scl_in && !scl_q) begin
      cnt <= cnt + 4'h1;
      if (cnt < 4'h8) sh <= {sh[6:0], sda_in};
      if (cnt == 4'h8 && rd && !first && sda_in) sel <= 1'b0;
    end else if (!scl_in && scl_q) begin
      if (cnt == 4'h8) begin
        if (first) begin
          sel <= (sh[7:1] == OWN_ADDR) && !nack_in;
          rd <= sh[0];
          sda_oe_out <= (sh[7:1] == OWN_ADDR) && !nack_in;
        end else if (sel && !rd) begin
          got_q.push_back(sh);
          sda_oe_out <= !nack_in;
        end else begin
          sda_oe_out <= 1'b0;
        end
      end else if (cnt == 4'h9) begin
        cnt <= 4'h0;
        first <= 1'b0;
        tx <= tx_byte_in;
        sda_oe_out <= sel && rd && !tx_byte_in[7];
      end else begin
        sda_oe_out <= sel && rd && !first && !tx[3'(4'h7 - cnt)];
      end
    end
  end
endmodule // i2c_slave_model

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import i2c_master_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, d_scl_oe, d_sda_oe, s_scl_oe, s_sda_oe, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] b, p;
  wire scl = !(d_scl_oe || s_scl_oe);
  wire sda = !(d_sda_oe || s_sda_oe);
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int t0;
  int exp_q[$];
  logic [7:0] ofs[8] = '{OFS_TARGET, OFS_CMD, OFS_DATA, OFS_PERIOD, OFS_IMASK, OFS_IRAW,
                         OFS_IMASKED, OFS_CONFIG};
  logic [31:0] rstv[8] = '{32'h0, 32'h20, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [3:0] cmds[4] = '{4'h3, 4'h1, 4'h3, 4'h7};
  logic [31:0] stv[4] = '{32'h40, 32'h40, 32'h40, 32'h20};

  i2c_master_command_sequencer dut_u (.clk_in(clk), .nrst_in(nrst), .axi_awaddr_in(awaddr),
    .axi_awvalid_in(awvalid), .axi_awready_out(awready), .axi_wdata_in(wdata),
    .axi_wstrb_in(wstrb), .axi_wvalid_in(wvalid), .axi_wready_out(wready),
    .axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
    .axi_araddr_in(araddr), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
    .axi_rready_in(rready), .scl_in(scl), .scl_level_out(), .scl_oe_out(d_scl_oe),
    .sda_in(sda), .sda_level_out(), .sda_oe_out(d_sda_oe), .irq_out(irq));
  i2c_slave_model slave_u (.clk_in(clk), .scl_in(scl), .sda_in(sda), .nack_in(nack),
    .stretch_in(stretch), .tx_byte_in(tx_byte), .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic run_cmd(input logic [3:0] c);
    wr(OFS_CMD, {28'h0, c}, r);
    do rd(OFS_CMD, v, r); while (v[ST_BUSY] !== 1'b0);
  endtask
  task automatic send(input logic [3:0] c);
    b = 8'($urandom);
    wr(OFS_DATA, {24'h0, b}, r);
    exp_q.push_back(int'(b));
    run_cmd(c);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(25754));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i], v, r);
      check(v, rstv[i], "reset value");
    end
    rd(8'h24, v, r);
    check(r, RESP_SLVERR, "unmapped read");
    wr(8'h24, 32'h1, r);
    check(r, RESP_SLVERR, "unmapped write");
    p = 8'($urandom_range(3));
    wr(OFS_PERIOD, {24'h0, p}, r);
    wr(OFS_TARGET, 32'h76, r);
    rd(OFS_TARGET, v, r);
    check(v, 32'h76, "target");
    b = 8'($urandom);
    wr(OFS_DATA, {24'h0, b}, r);
    exp_q.push_back(int'(b));
    wr(OFS_CMD, 32'h7, r);
    rd(OFS_CMD, v, r);
    check(v[ST_BUSY], 1'b1, "busy");
    @(posedge scl);
    t0 = int'($time);
    @(posedge scl);
    check(32'(int'($time) - t0), 32'(80 * (p + 1)), "bit period");
    @(posedge clk);
    stretch <= 1'b1;
    repeat (200) @(posedge clk);
    stretch <= 1'b0;
    rd(OFS_CMD, v, r);
    check(v[ST_BUS_OCC], 1'b1, "bus occupied");
    do rd(OFS_CMD, v, r); while (v[ST_BUSY] !== 1'b0);
    check(v, 32'h20, "single send");
    foreach (cmds[i]) begin
      send(cmds[i]);
      check(v, stv[i], "transmit sequence");
    end
    send(4'h3);
    check(v, 32'h40, "enter transmit");
    run_cmd(4'h4);
    check(v, 32'h20, "stop alone");
    @(posedge clk);
    nack <= 1'b1;
    wr(OFS_CMD, 32'h7, r);
    do rd(OFS_CMD, v, r); while (v[ST_BUSY] !== 1'b0);
    check(v, 32'h26, "address nack");
    @(posedge clk);
    nack <= 1'b0;
    tx_byte <= 8'($urandom);
    wr(OFS_TARGET, 32'h77, r);
    foreach (cmds[i]) begin
      run_cmd(i[0] ? 4'h3 : 4'hB);
      check(v, 32'h40, "enter receive");
      rd(OFS_DATA, v, r);
      check(v, {24'h0, tx_byte}, "received byte");
      run_cmd(i[0] ? 4'h4 : 4'h5);
      check(v, 32'h20, "receive end");
    end
    run_cmd(4'h7);
    check(v, 32'h20, "receive with stop");
    wr(OFS_TARGET, 32'h76, r);
    send(4'h3);
    wr(OFS_TARGET, 32'h77, r);
    run_cmd(4'hB);
    check(v, 32'h40, "restart to receive");
    run_cmd(4'h5);
    check(v, 32'h20, "receive then stop");
    foreach (stv[i]) begin
      run_cmd(i[0] ? 4'hF : {i[1], 3'b010});
      check(v, 32'h20, "no operation");
    end
    check(32'(slave_u.got_q.size()), 32'(exp_q.size()), "byte count");
    foreach (exp_q[i]) check(32'(slave_u.got_q[i]), 32'(exp_q[i]), "sent byte");
    wr(OFS_IMASK, 32'h1, r);
    rd(OFS_IMASKED, v, r);
    check(v, 32'h1, "masked interrupt");
    check(irq, 1'b1, "interrupt out");
    wr(OFS_ICLR, 32'h1, r);
    rd(OFS_IRAW, v, r);
    check(v, 32'h0, "raw cleared");
    check(irq, 1'b0, "interrupt cleared");
    complete_run();
  end
endmodule // testbench
